// file: rtl/drdc_rank_decode.sv
`timescale 1ns/100ps
`include "drdc_map.svh"
module drdc_rank_decode (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register access within the hub window.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Lock and settings held elsewhere.
  input wire logic stolen_memory_lock_owner,
  input wire drdc_pkg::drdc_bound_t rank0_boundary_field,
  input wire drdc_pkg::drdc_geom_t rank2_geometry_byte,
  input wire drdc_pkg::drdc_geom_t rank3_geometry_byte,
  // Access decode request, address in 64 MB units.
  input wire logic dec_req,
  input wire logic [9:0] dec_unit,
  // Decode result.
  output logic dec_valid,
  output logic dec_miss,
  output logic [3:0] dec_chip_sel,
  output logic [6:0] dec_cfg,
  output logic dec_eight_bank,
  output logic dec_cfg_known,
  output logic [3:0] dec_row_bits,
  output logic [3:0] dec_col_bits,
  output logic dec_page_8k
);

  drdc_pkg::drdc_bound_t rank1_boundary_field;
  drdc_pkg::drdc_bound_t rank2_boundary_field;
  drdc_pkg::drdc_bound_t rank3_boundary_field;
  drdc_pkg::drdc_geom_t rank0_geometry_byte;
  drdc_pkg::drdc_geom_t rank1_geometry_byte;
  logic wr_ok;
  logic [3:0] hit;
  logic [3:0] sel_next;
  drdc_pkg::drdc_geom_t geom_next;
  logic [15:0] rdata_next;
  drdc_pkg::drdc_bound_t bound_all [`DRDC_NUM_RANKS];

  // The lock shares this clock, so it is used without a synchroniser.
  assign wr_ok = clk_en && reg_wr && !stolen_memory_lock_owner; // [R4]

  // Bits 15:10 have no storage, so they ignore writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rank1_boundary_field <= `DRDC_BOUND_RESET;
      rank2_boundary_field <= `DRDC_BOUND_RESET;
      rank3_boundary_field <= `DRDC_BOUND_RESET;
    end else if (wr_ok) begin
      if (reg_addr == `DRDC_OFF_RANK1_BOUND) begin // [R1] [R13]
        if (reg_be[0]) begin
          rank1_boundary_field[7:0] <= reg_wdata[7:0];
        end
        if (reg_be[1]) begin
          rank1_boundary_field[9:8] <= reg_wdata[9:8];
        end
      end
      if (reg_addr == `DRDC_OFF_RANK2_BOUND) begin // [R2]
        if (reg_be[0]) begin
          rank2_boundary_field[7:0] <= reg_wdata[7:0];
        end
        if (reg_be[1]) begin
          rank2_boundary_field[9:8] <= reg_wdata[9:8];
        end
      end
      if (reg_addr == `DRDC_OFF_RANK3_BOUND) begin // [R3]
        if (reg_be[0]) begin
          rank3_boundary_field[7:0] <= reg_wdata[7:0];
        end
        if (reg_be[1]) begin
          rank3_boundary_field[9:8] <= reg_wdata[9:8];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rank0_geometry_byte <= `DRDC_GEOM_RESET;
      rank1_geometry_byte <= `DRDC_GEOM_RESET;
    end else if (wr_ok && reg_addr == `DRDC_OFF_RANK01_GEOM) begin // [R11]
      if (reg_be[0]) begin
        rank0_geometry_byte <= reg_wdata[7:0]; // [R6]
      end
      if (reg_be[1]) begin
        rank1_geometry_byte <= reg_wdata[15:8]; // [R6]
      end
    end
  end

  always_comb begin
    unique case (reg_addr)
      `DRDC_OFF_RANK1_BOUND: begin // [R13]
        rdata_next = {6'h00, rank1_boundary_field};
      end
      `DRDC_OFF_RANK2_BOUND: rdata_next = {6'h00, rank2_boundary_field};
      `DRDC_OFF_RANK3_BOUND: rdata_next = {6'h00, rank3_boundary_field};
      `DRDC_OFF_RANK01_GEOM: rdata_next = {rank1_geometry_byte,
                                          rank0_geometry_byte};
      default: rdata_next = 16'h0000;
    endcase
  end

  // A read in the same cycle as a write returns the old value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // Boundary 0 arrives from outside; the other three are held here.
  assign bound_all[0] = rank0_boundary_field;
  assign bound_all[1] = rank1_boundary_field;
  assign bound_all[2] = rank2_boundary_field;
  assign bound_all[3] = rank3_boundary_field;

  // The lowest-numbered rank whose boundary is above the address wins the chip select.
  for (genvar r = 0; r < `DRDC_NUM_RANKS; r++) begin : g_hit
    assign hit[r] = dec_unit < bound_all[r]; // [R12]
  end

  always_comb begin
    sel_next = 4'h0;
    geom_next = `DRDC_GEOM_RESET;
    if (hit[0]) begin
      sel_next = 4'h1;
      geom_next = rank0_geometry_byte;
    end else if (hit[1]) begin
      sel_next = 4'h2;
      geom_next = rank1_geometry_byte;
    end else if (hit[2]) begin
      sel_next = 4'h4;
      geom_next = rank2_geometry_byte;
    end else if (hit[3]) begin
      sel_next = 4'h8;
      geom_next = rank3_geometry_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid <= 1'b0;
      dec_miss <= 1'b0;
      dec_chip_sel <= 4'h0;
      dec_cfg <= 7'h00;
      dec_eight_bank <= 1'b0;
    end else if (clk_en) begin
      dec_valid <= dec_req && (sel_next != 4'h0); // [R12]
      dec_miss <= dec_req && (sel_next == 4'h0);
      if (dec_req) begin
        dec_chip_sel <= sel_next;
        dec_cfg <= geom_next[`DRDC_CFG_MSB:0]; // [R5] [R7]
        dec_eight_bank <= geom_next[`DRDC_BANK8_BIT]; // [R8]
      end
    end
  end

  // Unknown configurations report zero geometry and a cleared known flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cfg_known <= 1'b0;
      dec_row_bits <= 4'h0;
      dec_col_bits <= 4'h0;
      dec_page_8k <= 1'b0;
    end else if (clk_en && dec_req) begin
      dec_cfg_known <= geom_next[6:0] < 7'(`DRDC_NUM_CFGS); // [R9]
      dec_col_bits <= 4'ha;
      dec_page_8k <= 1'b1;
      unique case (geom_next[6:0]) // [R9]
        7'h00: dec_row_bits <= 4'hd;
        7'h01: begin
          dec_row_bits <= 4'hd;
          dec_col_bits <= 4'h9;
          dec_page_8k <= 1'b0;
        end
        7'h02: dec_row_bits <= 4'he;
        7'h03: dec_row_bits <= 4'hd;
        7'h04: dec_row_bits <= 4'hd;
        7'h05: dec_row_bits <= 4'hc;
        7'h06: dec_row_bits <= 4'he;
        7'h07: dec_row_bits <= 4'hd;
        default: begin
          dec_row_bits <= 4'h0;
          dec_col_bits <= 4'h0;
          dec_page_8k <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_lock_blocks_write: assert property ( // [R4]
    clk_en && reg_wr && stolen_memory_lock_owner |=>
      $stable(rank1_boundary_field) && $stable(rank2_boundary_field) &&
      $stable(rank3_boundary_field) &&
      $stable(rank0_geometry_byte) && $stable(rank1_geometry_byte))
    else $error("locked write changed a field");

  a_bound_write_stores: assert property ( // [R1]
    wr_ok && reg_addr == `DRDC_OFF_RANK1_BOUND && reg_be == 2'h3 |=>
      rank1_boundary_field == $past(reg_wdata[9:0]))
    else $error("rank 1 boundary write lost");

  a_rank2_write_stores: assert property ( // [R2]
    wr_ok && reg_addr == `DRDC_OFF_RANK2_BOUND && reg_be == 2'h3 |=>
      rank2_boundary_field == $past(reg_wdata[9:0]))
    else $error("rank 2 boundary write lost");

  a_rsvd_read_zero: assert property ( // [R13]
    clk_en && reg_rd && reg_addr == `DRDC_OFF_RANK3_BOUND |=>
      reg_rvalid && reg_rdata[15:10] == 6'h00 &&
      reg_rdata[9:0] == $past(rank3_boundary_field))
    else $error("boundary read wrong");

  a_geom_byte_order: assert property ( // [R6]
    clk_en && reg_rd && reg_addr == `DRDC_OFF_RANK01_GEOM |=>
      reg_rdata == {$past(rank1_geometry_byte), $past(rank0_geometry_byte)})
    else $error("geometry bytes swapped");

  a_rank1_select: assert property ( // [R12]
    clk_en && dec_req && !hit[0] && hit[1] |=>
      dec_valid && dec_chip_sel == 4'h2 &&
      dec_eight_bank == $past(rank1_geometry_byte[7]))
    else $error("rank 1 not selected");

  a_above_top_miss: assert property ( // [R12]
    clk_en && dec_req && !hit[3] && !hit[2] && !hit[1] && !hit[0] |=>
      dec_miss && !dec_valid)
    else $error("miss not flagged");

  a_cfg_from_byte: assert property ( // [R7]
    dec_valid && dec_chip_sel == 4'h1 && $past(clk_en) |->
      dec_cfg == $past(rank0_geometry_byte[6:0]))
    else $error("config index wrong");

  a_cfg1_geometry: assert property ( // [R9]
    clk_en && dec_req && geom_next[6:0] == 7'h01 |=>
      dec_row_bits == 4'hd && dec_col_bits == 4'h9 && !dec_page_8k)
    else $error("config 1 geometry wrong");

  a_sel_onehot: assert property ( // [R5]
    dec_valid |-> $onehot(dec_chip_sel) && !dec_miss)
    else $error("chip select not one-hot");

  a_rank3_write_stores: assert property ( // [R3]
    wr_ok && reg_addr == `DRDC_OFF_RANK3_BOUND && reg_be == 2'h3 |=>
      rank3_boundary_field == $past(reg_wdata[9:0]))
    else $error("rank 3 boundary write lost");

  // A lane 0 only write must leave rank 1's byte alone.
  a_geom_write_lanes: assert property ( // [R6]
    wr_ok && reg_addr == `DRDC_OFF_RANK01_GEOM && reg_be == 2'h1 |=>
      rank0_geometry_byte == $past(reg_wdata[7:0]) &&
      $stable(rank1_geometry_byte))
    else $error("geometry lane write wrong");

  a_rank0_select: assert property ( // [R12]
    clk_en && dec_req && hit[0] |=>
      dec_valid && dec_chip_sel == 4'h1 &&
      dec_eight_bank == $past(rank0_geometry_byte[7]))
    else $error("rank 0 not selected");

  a_rank3_select: assert property ( // [R12]
    clk_en && dec_req && hit == 4'h8 |=>
      dec_valid && dec_chip_sel == 4'h8 &&
      dec_cfg == $past(rank3_geometry_byte[6:0]))
    else $error("rank 3 not selected");

  a_cfg6_geometry: assert property ( // [R9]
    clk_en && dec_req && geom_next[6:0] == 7'h06 |=>
      dec_row_bits == 4'he && dec_col_bits == 4'ha && dec_page_8k &&
      dec_cfg_known)
    else $error("config 6 geometry wrong");

  a_unknown_cfg_zero: assert property ( // [R9]
    clk_en && dec_req && geom_next[6:0] > 7'h07 |=>
      !dec_cfg_known && dec_row_bits == 4'h0 && dec_col_bits == 4'h0 &&
      !dec_page_8k)
    else $error("unknown config not cleared");

  c_locked_write: cover property (wr_ok == 1'b0 && reg_wr &&
    stolen_memory_lock_owner && clk_en);
  c_rank3_hit: cover property (dec_valid && dec_chip_sel == 4'h8);
  c_eight_bank: cover property (dec_valid && dec_eight_bank &&
    dec_cfg == 7'h06);
  c_decode_miss: cover property (dec_miss);

endmodule // drdc_rank_decode

// file: rtl/drdc_map.svh
// Functional notes
// [R1] Rank 1 boundary: 10-bit sum of rank 0 and 1 sizes, 64 MB units.
// [R2] Rank 2 boundary: cumulative size of ranks 0 to 2 in bits 9:0.
// [R3] Rank 3 boundary: total of all four rank sizes in bits 9:0.
// [R4] Boundary and geometry fields ignore writes while the lock is set.
// [R5] A rank's geometry byte picks page size and bank count for its accesses.
// [R6] Geometry register: upper byte is rank 1, lower byte is rank 0.
// [R7] Geometry byte bits 6:0 are a configuration index, value n is config n.
// [R8] Geometry byte bit 7 selects bank count: 0 four banks, 1 eight banks.
// [R9] Configurations 0 to 7 map to fixed row, column and page geometries.
// [R10] Software leaves geometry bytes of unpopulated ranks at zero.
// [R11] Geometry registers sit at fixed offsets, channel 0 from 208h.
// [R12] Addresses compare with cumulative boundaries to pick a chip select.
// [R13] Boundary register bits 15:10 read as zero and ignore writes.
`ifndef DRDC_MAP_SVH
`define DRDC_MAP_SVH

`define DRDC_ADDR_W 12
`define DRDC_DATA_W 16
`define DRDC_OFF_RANK1_BOUND 12'h202
`define DRDC_OFF_RANK2_BOUND 12'h204
`define DRDC_OFF_RANK3_BOUND 12'h206
`define DRDC_OFF_RANK01_GEOM 12'h208
`define DRDC_BOUND_W 10
`define DRDC_BOUND_MSB 9
`define DRDC_CFG_MSB 6
`define DRDC_BANK8_BIT 7
`define DRDC_BOUND_RESET 10'h000
`define DRDC_GEOM_RESET 8'h00
`define DRDC_NUM_RANKS 4
`define DRDC_NUM_CFGS 8

`endif

// file: rtl/drdc_pkg.sv
package drdc_pkg;
  typedef logic [9:0] drdc_bound_t;
  typedef logic [7:0] drdc_geom_t;
  typedef logic [3:0] drdc_row_t;
endpackage

// file: verification/drdc_rank_model.sv
`timescale 1ns/100ps
module drdc_rank_model (
  // Settings held outside the decoder.
  output drdc_pkg::drdc_bound_t bound0,
  output drdc_pkg::drdc_geom_t geom2,
  output drdc_pkg::drdc_geom_t geom3
);
  // Rank 0 holds four units and rank 2 is empty, so its byte stays zero.
  assign bound0 = 10'h004;
  assign geom2 = 8'h00;
  assign geom3 = 8'h07;
endmodule // drdc_rank_model

// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [1:0] reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic lock = 1'b0;
  logic clk_en = 1'b1;
  logic dec_req = 1'b0;
  logic [9:0] dec_unit = 10'h000;
  logic [15:0] reg_rdata;
  logic reg_rvalid, dec_valid, dec_miss, eight, known, page;
  logic [3:0] sel, row, col;
  logic [6:0] cfg;
  drdc_pkg::drdc_bound_t bound0;
  drdc_pkg::drdc_geom_t geom2, geom3;
  logic [23:0] obs;
  int fail_count = 0;
  int total_checks = 0;
  // Geometry table, config 7 in the top slot.
  localparam logic [31:0] ROWS = 32'hd_e_c_d_d_e_d_d;
  localparam logic [7:0] PAGE = 8'hfd;
  assign obs = {dec_miss, dec_valid, sel, eight, known, page, cfg, row, col};
  drdc_rank_model model_u (.bound0(bound0), .geom2(geom2), .geom3(geom3));
  drdc_rank_decode dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .stolen_memory_lock_owner(lock), .rank0_boundary_field(bound0),
    .rank2_geometry_byte(geom2), .rank3_geometry_byte(geom3),
    .dec_req(dec_req), .dec_unit(dec_unit), .dec_valid(dec_valid),
    .dec_miss(dec_miss), .dec_chip_sel(sel), .dec_cfg(cfg),
    .dec_eight_bank(eight), .dec_cfg_known(known), .dec_row_bits(row),
    .dec_col_bits(col), .dec_page_8k(page));
  initial forever #25 clk = ~clk;
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({23'h000000, reg_rvalid}, 24'h000001);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task dec(input logic [9:0] u);
    @(posedge clk);
    dec_req <= 1'b1;
    dec_unit <= u;
    @(posedge clk);
    dec_req <= 1'b0;
    #1;
  endtask
  // Expected decode outputs worked out from the geometry table.
  function logic [23:0] ex(input logic [3:0] s, input logic [7:0] g);
    logic k;
    logic [3:0] r, c;
    k = (g[6:0] < 7'd8);
    r = k ? ROWS[g[2:0] * 4 +: 4] : 4'h0;
    c = k ? ((g[2:0] == 3'd1) ? 4'd9 : 4'd10) : 4'h0;
    ex = {s == 4'h0, s != 4'h0, s, g[7], k, k & PAGE[g[2:0]], g[6:0], r, c};
  endfunction
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(12'h202 + 12'(2 * i), 16'h0000);
    wr(12'h202, 2'h3, 16'hffff);
    rd(12'h202, 16'h03ff);
    wr(12'h202, 2'h3, 16'h0008);
    wr(12'h204, 2'h3, 16'h0008);
    wr(12'h206, 2'h3, 16'hfc0c);
    rd(12'h204, 16'h0008);
    rd(12'h206, 16'h000c);
    wr(12'h208, 2'h1, 16'hee81);
    wr(12'h208, 2'h2, 16'h06ee);
    rd(12'h208, 16'h0681);
    rd(12'h20a, 16'h0000);
    $display("test registers done");
    dec(10'd2);
    chk(obs, ex(4'b0001, 8'h81));
    dec(10'd5);
    chk(obs, ex(4'b0010, 8'h06));
    dec(10'd8);
    chk(obs, ex(4'b1000, geom3));
    dec(10'd12);
    chk({18'h00000, obs[23:18]}, 24'h000020);
    $display("test decode done");
    for (int i = 0; i < 9; i++) begin
      wr(12'h208, 2'h1, {8'h00, i[0], 1'b0, i[5:0]});
      dec(10'd0);
      chk(obs, ex(4'b0001, {i[0], 1'b0, i[5:0]}));
    end
    $display("test geometry table done");
    @(posedge clk);
    clk_en <= 1'b0;
    wr(12'h202, 2'h3, 16'h0001);
    dec(10'd5);
    chk({18'h00000, obs[23:18]}, 24'h000001);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(12'h202, 16'h0008);
    $display("test freeze done");
    @(posedge clk);
    lock <= 1'b1;
    wr(12'h202, 2'h3, 16'h0001);
    wr(12'h208, 2'h3, 16'h0000);
    rd(12'h202, 16'h0008);
    rd(12'h208, 16'h0608);
    $display("test lock done");
    tally_and_finish();
  end
endmodule // testbench
